// ==== hdl/rmsp_top.sv ====
// Reset pin sequencer, reset cause recorder, mode-select sampling,
// debug pin control, interrupt pin handling and shared-pin multiplexer.
// Assumes one 50 MHz clock, pad ring resolving out/oe/pull per pin,
// and port registers, peripherals and the debug protocol outside.
`timescale 1ns/1ps
`include "rmsp_consts.svh"

module rmsp_top (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_b_i,
	// Internal reset sources, one-cycle or level requests
	input  wire logic                   lvd_rst_i,
	input  wire logic                   cop_rst_i,
	input  wire logic                   ilop_rst_i,
	input  wire logic                   dbg_rst_i,
	// Reset pin
	input  wire logic                   rst_pin_i,
	output logic                        rst_pin_o,
	output logic                        rst_pin_oe_o,
	// Reset results
	output logic                        sys_rst_b_o,
	output logic [7:0]                  reset_cause_register_o,
	// Debug / mode-select pin
	input  wire logic                   debug_modesel_pin_i,
	output logic                        debug_modesel_pin_o,
	output logic                        debug_modesel_pin_oe_o,
	output logic                        debug_modesel_pu_o,
	// Background debug controller side
	input  wire logic                   bdc_drive_low_i,
	input  wire logic                   bdc_speedup_i,
	input  wire logic                   bdc_bgnd_i,
	input  wire logic                   bdc_go_i,
	input  wire logic                   bdc_clk_alt_i,
	output logic                        bdc_bit_tick_o,
	output logic                        bdc_rx_o,
	output logic                        bg_mode_o,
	output logic                        cpu_halt_o,
	// External interrupt pin
	input  wire logic                   irq_pin_i,
	input  wire logic                   irq_en_i,
	input  wire logic                   irq_rise_i,
	input  wire logic                   irq_pull_en_i,
	output logic                        irq_pu_o,
	output logic                        irq_pd_o,
	output logic                        irq_level_o,
	output logic                        irq_req_o,
	// Timer external clocks
	input  wire logic                   timer_clock_route_sel_i,
	output logic                        timer1_ext_clock_in_o,
	output logic                        timer2_ext_clock_in_o,
	output logic                        timer3_ext_clock_in_o,
	// Shared pins, port side
	input  wire logic [`RMSP_NPINS-1:0] pad_i,
	input  wire logic [`RMSP_NPINS-1:0] port_data_i,
	input  wire logic [`RMSP_NPINS-1:0] port_dir_i,
	input  wire logic [`RMSP_NPINS-1:0] port_pull_en_i,
	// Shared pins, peripheral side
	input  wire rmsp_pkg::rmsp_pinfn_s  alt1_i,
	input  wire rmsp_pkg::rmsp_pinfn_s  alt2_i,
	input  wire logic [`RMSP_NPINS-1:0] kbi_rise_i,
	// Shared pins, pad and readback
	output rmsp_pkg::rmsp_pad_s         pad_o,
	output logic [`RMSP_NPINS-1:0]      port_rd_o
);

	// ************************************************************
	// Local constants
	// ************************************************************
	localparam logic [2:0] OSC_LAST  = 3'(`RMSP_OSC_DIV - 1);
	localparam logic [5:0] TICK_LAST = 6'(`RMSP_RST_DRIVE_TICKS - 1);
	localparam logic [3:0] BIT_LAST  = 4'(`RMSP_DBG_BIT_CLKS - 1);
	localparam int         SW        = `RMSP_NPINS + 3;

	// ************************************************************
	// State record
	// ************************************************************
	typedef struct packed {
		rmsp_pkg::rmsp_rst_e    fsm;        // Reset sequencer
		logic [2:0]             div_cnt;    // Reset oscillator divider
		logic [5:0]             tick_cnt;   // Drive-low tick count
		logic [7:0]             cause;      // Reset cause flags
		logic                   sys_rst_b;  // Chip reset, low active
		logic                   rst_oe;     // Driving reset pin low
		logic                   bg_mode;    // Active background mode
		logic                   dbg_out;    // Debug pin output level
		logic                   dbg_oe;     // Debug pin output enable
		logic [3:0]             bit_cnt;    // Debug clocks within a bit
		logic                   dbg_prev;   // Debug level, last cycle
		logic                   bit_tick;   // End of a debug bit time
		logic                   dbg_rx;     // Debug level toward the BDC
		logic                   irq_prev;   // Interrupt level, last cycle
		logic                   irq_level;  // Interrupt level for branches
		logic                   irq_req;    // Interrupt edge request
		logic                   irq_pu;     // Interrupt pin pullup
		logic                   irq_pd;     // Interrupt pin pulldown
		logic [2:0]             tmr_clk;    // Timer clocks 3..1
		rmsp_pkg::rmsp_pad_s    pad;        // Shared pad controls
		logic [`RMSP_NPINS-1:0] port_rd;    // Port readback
	} rmsp_top_s;

	rmsp_top_s st_ff;   // Current state
	rmsp_top_s nxt_st;  // Next state

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [SW-1:0]          sync_lv;     // Settled pin levels
	logic                   rst_pin_s;   // Reset pin, settled
	logic                   modesel_s;   // Mode-select pin, settled
	logic                   irq_pin_s;   // Interrupt pin, settled
	logic [`RMSP_NPINS-1:0] pad_s;       // Shared pins, settled

	rmsp_sync #(
		.W (SW)
	) u_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.async_i ({rst_pin_i, debug_modesel_pin_i, irq_pin_i, pad_i}),
		.sync_o  (sync_lv)
	);

	assign rst_pin_s = sync_lv[SW-1];
	assign modesel_s = sync_lv[SW-2];
	assign irq_pin_s = sync_lv[SW-3];
	assign pad_s     = sync_lv[`RMSP_NPINS-1:0];

	// ************************************************************
	// Shared pin cells
	// ************************************************************
	rmsp_pkg::rmsp_pad_s    cell_pad;  // Pad controls before reset gating
	logic [`RMSP_NPINS-1:0] cell_rd;   // Readback from each cell

	// Only the four keyboard pins carry a pulldown device
	genvar gi;
	generate
		for (gi = 0; gi < `RMSP_NPINS; gi++) begin : g_pin
			rmsp_pin_cell #(
				.HAS_PD (1'((`RMSP_KBI_PD_MASK >> gi) & 1))
			) u_cell (
				.pin_i      (pad_s[gi]),
				.port_out_i (port_data_i[gi]),
				.port_dir_i (port_dir_i[gi]),
				.pull_en_i  (port_pull_en_i[gi]),
				.a1_en_i    (alt1_i.en[gi]),
				.a1_out_i   (alt1_i.out[gi]),
				.a1_oe_i    (alt1_i.oe[gi]),
				.a1_rise_i  (kbi_rise_i[gi]),
				.a2_en_i    (alt2_i.en[gi]),
				.a2_out_i   (alt2_i.out[gi]),
				.a2_oe_i    (alt2_i.oe[gi]),
				.pad_out_o  (cell_pad.out[gi]),
				.pad_oe_o   (cell_pad.oe[gi]),
				.pu_o       (cell_pad.pu[gi]),
				.pd_o       (cell_pad.pd[gi]),
				.rd_o       (cell_rd[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Next state
	// ************************************************************
	logic       osc_tick;   // Self-clocked reset oscillator tick
	logic       dbg_tick;   // One debug-controller clock
	logic [7:0] new_cause;  // Causes seen this cycle
	logic [2:0] tsrc;       // Timer clock sources: irq, d5, d4

	always_comb begin
		nxt_st    = st_ff;
		osc_tick  = (st_ff.div_cnt == OSC_LAST);
		// Reset oscillator is stood in for by a divided bus clock
		nxt_st.div_cnt = osc_tick ? 3'h0 : st_ff.div_cnt + 3'h1;

		// Gather every reset source of this cycle
		new_cause = 8'h00;
		new_cause[`RMSP_CAUSE_PIN]  = ~rst_pin_s;
		new_cause[`RMSP_CAUSE_COP]  = cop_rst_i;
		new_cause[`RMSP_CAUSE_ILOP] = ilop_rst_i;
		new_cause[`RMSP_CAUSE_DBG]  = dbg_rst_i;
		new_cause[`RMSP_CAUSE_LVD]  = lvd_rst_i;

		// Reset sequencer
		unique case (st_ff.fsm)
			rmsp_pkg::ST_DRIVE: begin
				// Drive the pin low for a fixed tick count
				nxt_st.rst_oe = 1'b1;
				if (osc_tick) begin
					if (st_ff.tick_cnt == TICK_LAST) begin
						nxt_st.fsm    = rmsp_pkg::ST_HOLD;
						nxt_st.rst_oe = 1'b0;
					end else begin
						nxt_st.tick_cnt = st_ff.tick_cnt + 6'h01;
					end
				end
			end
			rmsp_pkg::ST_HOLD: begin
				// Stay in reset while someone outside holds the pin low
				if (rst_pin_s) begin
					nxt_st.fsm       = rmsp_pkg::ST_RUN;
					nxt_st.sys_rst_b = 1'b1;
					// Sample mode select at the release
					nxt_st.bg_mode   = ~modesel_s;
				end
			end
			rmsp_pkg::ST_RUN: begin
				if (|new_cause) begin
					// New reset: old causes replaced by the new
					nxt_st.fsm       = rmsp_pkg::ST_DRIVE;
					nxt_st.cause     = new_cause;
					nxt_st.tick_cnt  = 6'h00;
					nxt_st.rst_oe    = 1'b1;
					nxt_st.sys_rst_b = 1'b0;
					nxt_st.bg_mode   = 1'b0;
				end else if (bdc_bgnd_i) begin
					// Enter background mode; wins over a resume
					nxt_st.bg_mode = 1'b1;
				end else if (bdc_go_i) begin
					nxt_st.bg_mode = 1'b0;
				end
			end
			default: begin
				// Illegal code recovers through a full reset sequence
				nxt_st.fsm       = rmsp_pkg::ST_DRIVE;
				nxt_st.tick_cnt  = 6'h00;
				nxt_st.sys_rst_b = 1'b0;
			end
		endcase

		// Debug pin: input only while in reset
		if (nxt_st.fsm == rmsp_pkg::ST_RUN) begin
			// Pseudo open-drain with brief driven-high speedups
			nxt_st.dbg_oe  = bdc_drive_low_i | bdc_speedup_i;
			nxt_st.dbg_out = bdc_speedup_i & ~bdc_drive_low_i;
		end else begin
			nxt_st.dbg_oe  = 1'b0;
			nxt_st.dbg_out = 1'b0;
		end

		// Debug bit timing; clock is the bus clock or the slow one
		dbg_tick        = bdc_clk_alt_i ? osc_tick : 1'b1;
		nxt_st.dbg_prev = modesel_s;
		nxt_st.dbg_rx   = modesel_s;
		nxt_st.bit_tick = 1'b0;
		if (st_ff.dbg_prev & ~modesel_s) begin
			// A falling edge starts every bit; realign there
			nxt_st.bit_cnt = 4'h0;
		end else if (dbg_tick) begin
			// Sixteen debug clocks make one bit time
			nxt_st.bit_cnt  = st_ff.bit_cnt + 4'h1;
			nxt_st.bit_tick = (st_ff.bit_cnt == BIT_LAST);
		end

		// Interrupt pin: level for branches, edge request
		nxt_st.irq_prev  = irq_pin_s;
		nxt_st.irq_level = irq_pin_s;
		nxt_st.irq_req   = irq_en_i &
			(irq_rise_i ? (irq_pin_s & ~st_ff.irq_prev) : (~irq_pin_s & st_ff.irq_prev));
		// Rising-edge sense turns the pull into a pulldown
		nxt_st.irq_pu = irq_en_i & irq_pull_en_i & ~irq_rise_i;
		nxt_st.irq_pd = irq_en_i & irq_pull_en_i & irq_rise_i;

		// Timer clock routing; interrupt pin free only when unused
		tsrc = {irq_pin_s & ~irq_en_i, pad_s[`RMSP_PIN_TMR1CLK], pad_s[`RMSP_PIN_TMR2CLK]};
		if (timer_clock_route_sel_i) begin
			// Alternate assignment rotates the three sources
			nxt_st.tmr_clk = {tsrc[0], tsrc[1], tsrc[2]};
		end else begin
			// Default assignment: pins to timers one, two, three
			nxt_st.tmr_clk = {tsrc[2], tsrc[0], tsrc[1]};
		end

		// Shared pins: high impedance, pulls off while in reset
		if (nxt_st.sys_rst_b) begin
			nxt_st.pad = cell_pad;
		end else begin
			nxt_st.pad = '0;
		end
		nxt_st.port_rd = cell_rd;

		// No interrupt request leaves during reset regardless of the pin
		if (!nxt_st.sys_rst_b) begin
			nxt_st.irq_req = 1'b0;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// Power-up counts as a reset with its own cause
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_ff           <= '0;
			st_ff.fsm       <= rmsp_pkg::ST_DRIVE;
			st_ff.cause     <= `RMSP_CAUSE_RST;
			st_ff.rst_oe    <= 1'b1;
			st_ff.dbg_prev  <= 1'b1;
			st_ff.irq_prev  <= 1'b1;
			st_ff.irq_level <= 1'b1;
			st_ff.dbg_rx    <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ************************************************************
	// Outputs, straight from the state record except two constants
	// ************************************************************
	assign rst_pin_o              = 1'b0;
	assign rst_pin_oe_o           = st_ff.rst_oe;
	assign sys_rst_b_o            = st_ff.sys_rst_b;
	assign reset_cause_register_o = st_ff.cause;
	assign debug_modesel_pin_o    = st_ff.dbg_out;
	assign debug_modesel_pin_oe_o = st_ff.dbg_oe;
	// Pullup stays on in both roles of the pin
	assign debug_modesel_pu_o     = 1'b1;
	assign bdc_bit_tick_o         = st_ff.bit_tick;
	assign bdc_rx_o               = st_ff.dbg_rx;
	assign bg_mode_o              = st_ff.bg_mode;
	// Processor suspended while background mode holds
	assign cpu_halt_o             = st_ff.bg_mode;
	assign irq_pu_o               = st_ff.irq_pu;
	assign irq_pd_o               = st_ff.irq_pd;
	assign irq_level_o            = st_ff.irq_level;
	assign irq_req_o              = st_ff.irq_req;
	assign timer1_ext_clock_in_o  = st_ff.tmr_clk[0];
	assign timer2_ext_clock_in_o  = st_ff.tmr_clk[1];
	assign timer3_ext_clock_in_o  = st_ff.tmr_clk[2];
	assign pad_o                  = st_ff.pad;
	assign port_rd_o              = st_ff.port_rd;

endmodule

// ==== hdl/rmsp_consts.svh ====
// Constants of the reset, mode-select and shared-pin block: timing, cause
// bits, pin indices and reset values.
// Assumes a 50 MHz bus clock and a single clock domain.
`ifndef RMSP_CONSTS_SVH
`define RMSP_CONSTS_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define RMSP_CLK_KHZ         50000
`define RMSP_SELF_RESET_KHZ  8000
`define RMSP_OSC_DIV         (`RMSP_CLK_KHZ / `RMSP_SELF_RESET_KHZ)
`define RMSP_RST_DRIVE_TICKS 34
`define RMSP_DBG_BIT_CLKS    16

// ************************************************************
// Reset cause bits and reset values
// ************************************************************
`define RMSP_CAUSE_POR   7
`define RMSP_CAUSE_PIN   6
`define RMSP_CAUSE_COP   5
`define RMSP_CAUSE_ILOP  4
`define RMSP_CAUSE_DBG   2
`define RMSP_CAUSE_LVD   1
`define RMSP_CAUSE_RST   8'h80

// ************************************************************
// Shared pins
// ************************************************************
`define RMSP_NPINS       8
`define RMSP_KBI_PD_MASK 8'h0f
`define RMSP_PIN_TMR2CLK 4
`define RMSP_PIN_TMR1CLK 5

`endif

// ==== hdl/rmsp_pkg.sv ====
// Types shared by the reset, mode-select and shared-pin block.
// Assumes rmsp_consts.svh is available on the include path.
`include "rmsp_consts.svh"

package rmsp_pkg;

	// Reset sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_DRIVE = 3'b001,
		ST_HOLD  = 3'b010,
		ST_RUN   = 3'b100
	} rmsp_rst_e;

	// One alternate function over all shared pins
	typedef struct packed {
		logic [`RMSP_NPINS-1:0] en;
		logic [`RMSP_NPINS-1:0] out;
		logic [`RMSP_NPINS-1:0] oe;
	} rmsp_pinfn_s;

	// Pad controls toward the pad ring
	typedef struct packed {
		logic [`RMSP_NPINS-1:0] out;
		logic [`RMSP_NPINS-1:0] oe;
		logic [`RMSP_NPINS-1:0] pu;
		logic [`RMSP_NPINS-1:0] pd;
	} rmsp_pad_s;

endpackage

// ==== hdl/rmsp_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous levels; only the second stage is used.
`timescale 1ns/1ps

module rmsp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// Both stages live in one state record
	typedef struct packed {
		logic [W-1:0] s1;  // First stage, read only by s2
		logic [W-1:0] s2;  // Settled copy
	} rmsp_sync_s;

	rmsp_sync_s st_ff;   // Current state
	rmsp_sync_s nxt_st;  // Next state

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = async_i;
		nxt_st.s2 = st_ff.s1;
	end

	// Registers; pins are treated as high while in reset
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_ff <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_o = st_ff.s2;

endmodule

// ==== hdl/rmsp_pin_cell.sv ====
// One shared pin: priority selection among port, first and second
// alternate function, pull selection and readback.
// Assumes the pin level is already synchronised; purely combinational.
`timescale 1ns/1ps

module rmsp_pin_cell #(
	parameter bit HAS_PD = 1'b0
) (
	// Pin level
	input  wire logic pin_i,
	// Port function
	input  wire logic port_out_i,
	input  wire logic port_dir_i,
	input  wire logic pull_en_i,
	// First alternate function
	input  wire logic a1_en_i,
	input  wire logic a1_out_i,
	input  wire logic a1_oe_i,
	input  wire logic a1_rise_i,
	// Second alternate function
	input  wire logic a2_en_i,
	input  wire logic a2_out_i,
	input  wire logic a2_oe_i,
	// Pad controls and readback
	output logic      pad_out_o,
	output logic      pad_oe_o,
	output logic      pu_o,
	output logic      pd_o,
	output logic      rd_o
);

	logic want_pd;  // Pull goes low instead of high

	// ************************************************************
	// Owner selection and pull
	// ************************************************************
	always_comb begin
		want_pd = 1'b0;
		// Second alternate beats first, first beats the port
		if (a2_en_i) begin
			pad_out_o = a2_out_i;
			pad_oe_o  = a2_oe_i;
		end else if (a1_en_i) begin
			pad_out_o = a1_out_i;
			pad_oe_o  = a1_oe_i;
			// Keyboard owner with rising sense flips the pull
			want_pd   = HAS_PD & a1_rise_i;
		end else begin
			pad_out_o = port_out_i;
			pad_oe_o  = port_dir_i;
		end
		// Pull acts only while nothing drives the pin
		pu_o = pull_en_i & ~pad_oe_o & ~want_pd;
		pd_o = pull_en_i & ~pad_oe_o & want_pd;
		// Direction still decides what a port read returns
		rd_o = port_dir_i ? port_out_i : pin_i;
	end

endmodule

// ==== test/rmsp_host.sv ====
// Debug host model: holds the debug line low across the reset release.
// Assumes the bench resolves the wired line from all drivers.
`timescale 1ns/1ps

module rmsp_host (
	// Clock and chip reset state
	input  wire logic clk_i,
	input  wire logic sys_rst_b_i,
	// Host wish and line drive
	input  wire logic want_bg_i,
	output logic      hold_low_o
);
	// Cycles still to hold after release; the line is only ever pulled low
	logic [3:0] left_ff = 4'hf;

	// Reload in reset, count down afterwards, so the level is stable
	// well past the sampling edge
	always_ff @(posedge clk_i) begin
		if (!sys_rst_b_i)
			left_ff <= 4'hf;
		else if (left_ff != 4'h0)
			left_ff <= left_ff - 4'h1;
	end
	assign hold_low_o = want_bg_i && (left_ff != 4'h0);
endmodule

// ==== test/rmsp_top_chk.sv ====
// Checker for the reset, mode-select and shared-pin block.
// Assumes it is bound to rmsp_top and sees only its ports.
`timescale 1ns/1ps
`include "rmsp_consts.svh"

module rmsp_top_chk (
	// Clock, reset and requests
	input wire logic clk_i, rst_b_i, cop_rst_i,
	input wire logic bdc_clk_alt_i, irq_en_i, irq_pull_en_i, irq_rise_i,
	input wire logic debug_modesel_pin_i,
	input wire rmsp_pkg::rmsp_pinfn_s alt1_i, alt2_i,
	input wire logic [`RMSP_NPINS-1:0] port_dir_i,
	// Outputs watched
	input wire logic rst_pin_o, rst_pin_oe_o, sys_rst_b_o, debug_modesel_pin_oe_o,
	input wire logic bdc_bit_tick_o, bg_mode_o, cpu_halt_o,
	input wire logic irq_pu_o, irq_pd_o, irq_req_o,
	input wire logic [7:0] reset_cause_register_o,
	input wire rmsp_pkg::rmsp_pad_s pad_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// Enable of the winning function: second alternate, first, then port
	logic [`RMSP_NPINS-1:0] win_oe;
	assign win_oe = alt2_i.en & alt2_i.oe | alt1_i.en & ~alt2_i.en & alt1_i.oe
		| ~alt1_i.en & ~alt2_i.en & port_dir_i;

	a_rst_pin_low: assert property (rst_pin_oe_o |-> !rst_pin_o)
		else $error("reset pin driven high");
	a_src_to_rst: assert property (sys_rst_b_o && cop_rst_i |=>
		rst_pin_oe_o && !sys_rst_b_o && reset_cause_register_o[`RMSP_CAUSE_COP])
		else $error("watchdog request did not reset");
	a_dbg_input: assert property (!sys_rst_b_o && !$past(sys_rst_b_o)
		|-> !debug_modesel_pin_oe_o)
		else $error("debug pin driven in reset");
	a_mode_latch: assert property ($rose(sys_rst_b_o)
		|-> ##2 bg_mode_o != debug_modesel_pin_i)
		else $error("mode not taken from pin");
	a_halt_follows: assert property (cpu_halt_o == bg_mode_o)
		else $error("halt differs from mode");
	a_bit_period: assert property (bdc_bit_tick_o && !bdc_clk_alt_i
		|=> !bdc_bit_tick_o [*8] ##1 !bdc_bit_tick_o [*7])
		else $error("debug bit shorter than sixteen clocks");
	a_irq_pulldn: assert property ((sys_rst_b_o && irq_en_i && irq_pull_en_i
		&& irq_rise_i) [*2] |-> irq_pd_o && !irq_pu_o)
		else $error("rising irq not pulled down");
	a_irq_pulse: assert property (irq_req_o |=> !irq_req_o)
		else $error("irq request longer than one cycle");
	a_pad_owner: assert property (sys_rst_b_o && $past(sys_rst_b_o)
		|-> pad_o.oe == $past(win_oe))
		else $error("pad enable not from winner");
	a_pins_reset: assert property (!sys_rst_b_o |-> pad_o.oe == 0
		&& pad_o.pu == 0 && pad_o.pd == 0)
		else $error("shared pin active in reset");

	cover property (bg_mode_o);
	cover property (irq_req_o);
	cover property (bdc_bit_tick_o);
	cover property ($fell(sys_rst_b_o));
endmodule

bind rmsp_top rmsp_top_chk u_chk (.*);

// ==== test/reset_mode_select_pin_mux_bench.sv ====
// Self-checking bench for the reset, mode-select and shared-pin block.
// Assumes a single 50 MHz clock; the bench resolves both wired pins.
`timescale 1ns/1ps
`include "rmsp_consts.svh"

module reset_mode_select_pin_mux_bench;
	// One mux case: both alternates in, pad controls out
	typedef struct packed {
		rmsp_pkg::rmsp_pinfn_s a1, a2;
		rmsp_pkg::rmsp_pad_s   pad;
	} rmsp_row_s;
	rmsp_row_s rows [4] = '{{24'h0, 24'h0, 32'hf0cc3300},
		{24'h0f0503, 24'h0, 32'hf5c3300c}, {24'hff00ff, 24'h3c3c0c, 32'h3ccf3000},
		{24'h0f0000, 24'h0, 32'hf0c0300f}};
	logic [3:0] src [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
	logic [7:0] cause [5] = '{8'h02, 8'h20, 8'h10, 8'h04, 8'h40};
	logic clk_i = 0, rst_b_i = 0, lvd_rst_i = 0, cop_rst_i = 0, ilop_rst_i = 0;
	logic dbg_rst_i = 0, bdc_drive_low_i = 0, bdc_speedup_i = 0, bdc_bgnd_i = 0;
	logic bdc_go_i = 0, bdc_clk_alt_i = 0, irq_pin_i = 1, irq_en_i = 0, irq_rise_i = 0;
	logic irq_pull_en_i = 0, timer_clock_route_sel_i = 0, ext_low = 0, want_bg = 1;
	logic [7:0] pad_i = 8'h5a, port_data_i = 8'hf0, port_dir_i = 8'hcc;
	logic [7:0] port_pull_en_i = 8'hff, kbi_rise_i = 8'hff;
	rmsp_pkg::rmsp_pinfn_s alt1_i = '0, alt2_i = '0;
	wire logic rst_pin_i, debug_modesel_pin_i, host_low;
	logic rst_pin_o, rst_pin_oe_o, sys_rst_b_o, debug_modesel_pin_o, debug_modesel_pin_oe_o;
	logic debug_modesel_pu_o, bdc_bit_tick_o, bdc_rx_o, bg_mode_o, cpu_halt_o, irq_pu_o;
	logic irq_pd_o, irq_level_o, irq_req_o;
	logic timer1_ext_clock_in_o, timer2_ext_clock_in_o, timer3_ext_clock_in_o;
	logic [7:0] reset_cause_register_o, port_rd_o;
	rmsp_pkg::rmsp_pad_s pad_o;
	int n_errors = 0, samples_checked = 0, cycles = 0;

	// Both pins idle high through their pullups; lows win
	assign rst_pin_i = !(ext_low || rst_pin_oe_o && !rst_pin_o);
	assign debug_modesel_pin_i = !host_low
		&& (debug_modesel_pin_oe_o ? debug_modesel_pin_o : 1'b1);

	rmsp_top dut (.*);
	rmsp_host u_host (.clk_i(clk_i), .sys_rst_b_i(sys_rst_b_o), .want_bg_i(want_bg),
		.hold_low_o(host_low));

	always #10 clk_i = ~clk_i;

	// Hang guard, far beyond the roughly 1500 cycles expected
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Step n edges, then land just after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	// Check cause and mode after run resumes, then leave background mode
	task automatic after_rst(input logic [7:0] exp);
		chk(reset_cause_register_o, exp);
		chk(debug_modesel_pu_o, 1);
		cyc(3);
		chk({bg_mode_o, cpu_halt_o}, {2{want_bg}});
		bdc_go_i = 1;
		cyc(1);
		bdc_go_i = 0;
		cyc(20);
	endtask

	// One reset from a source set, or from the pin when the set is empty
	task automatic do_rst(input logic [3:0] s, input logic [7:0] exp);
		int n = 3;
		want_bg = (s == 4'h0);
		ext_low = want_bg;
		{lvd_rst_i, cop_rst_i, ilop_rst_i, dbg_rst_i} = s;
		cyc(1);
		{lvd_rst_i, cop_rst_i, ilop_rst_i, dbg_rst_i} = 4'h0;
		cyc(3);
		ext_low = 0;
		chk({pad_o.oe, pad_o.pu, pad_o.pd}, 0);
		for (int k = 0; k < 900 && !sys_rst_b_o; k++) begin
			n += rst_pin_oe_o;
			cyc(1);
		end
		chk(want_bg || n inside {[199:204]}, 1);
		after_rst(exp);
	endtask

	initial begin
		int n;
		cyc(12);
		rst_b_i = 1;
		for (int k = 0; k < 900 && !sys_rst_b_o; k++)
			cyc(1);
		after_rst(8'h80);
		foreach (rows[i]) begin
			// Software side: drop every sharer for a cycle before the next owner
			alt1_i = '0;
			alt2_i = '0;
			cyc(1);
			alt1_i = rows[i].a1;
			alt2_i = rows[i].a2;
			cyc(3);
			chk(pad_o, rows[i].pad);
			chk(port_rd_o, 8'hd2);
		end
		for (int i = 0; i < 5; i++)
			do_rst(src[i], cause[i]);
		// Debug line: pull low, then speedup drive high
		bdc_drive_low_i = 1;
		cyc(4);
		chk({debug_modesel_pin_oe_o, debug_modesel_pin_o, bdc_rx_o}, 3'b100);
		bdc_drive_low_i = 0;
		bdc_speedup_i = 1;
		cyc(4);
		chk({debug_modesel_pin_oe_o, debug_modesel_pin_o, bdc_rx_o}, 3'b111);
		bdc_speedup_i = 0;
		n = 0;
		repeat (32) begin
			cyc(1);
			n += bdc_bit_tick_o;
		end
		chk(n, 2);
		bdc_bgnd_i = 1;
		cyc(1);
		bdc_bgnd_i = 0;
		cyc(2);
		chk(cpu_halt_o, 1);
		// Interrupt pin: pullup, falling request, then pulldown
		irq_en_i = 1;
		irq_pull_en_i = 1;
		cyc(2);
		chk({irq_pu_o, irq_pd_o}, 2'b10);
		irq_pin_i = 0;
		n = 0;
		repeat (6) begin
			cyc(1);
			n += irq_req_o;
		end
		chk(n, 1);
		chk(irq_level_o, 0);
		irq_rise_i = 1;
		cyc(2);
		chk({irq_pu_o, irq_pd_o}, 2'b01);
		// Timer clock routing, both settings
		irq_en_i = 0;
		pad_i = 8'h20;
		cyc(4);
		chk({timer1_ext_clock_in_o, timer2_ext_clock_in_o, timer3_ext_clock_in_o}, 3'b100);
		timer_clock_route_sel_i = 1;
		cyc(4);
		chk({timer1_ext_clock_in_o, timer2_ext_clock_in_o, timer3_ext_clock_in_o}, 3'b010);
		finish_test();
	end
endmodule
